// file: src/exc_ctrl_pkg.sv
/*
 * Constants shared by the exception mode stack controller: register map,
 * field positions, reset values, cause codes and the exception vector.
 * Assumes a 32-bit APB register bus and a single 50 MHz processor clock.
 */
package exc_ctrl_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] STATUS_OFS   = 8'h00;
    localparam logic [7:0] CAUSE_OFS    = 8'h04;
    localparam logic [7:0] BRANCH_CONDITION_INPUT_OFS   = 8'h08;
    localparam logic [7:0] EVT_STAT_OFS = 8'h0C;
    localparam logic [7:0] EVT_MASK_OFS = 8'h10;

    // ==========================================================
    // Field layout
    localparam int STACK_W   = 6;   // old/previous/current pairs, {user, enable}
    localparam int CUR_IE    = 0;
    localparam int CUR_UM    = 1;
    localparam int MASK_LO   = 8;   // status mask, cause pending share bits 15:8
    localparam int NUM_INT   = 8;
    localparam int NUM_SW    = 2;
    localparam int NUM_HW    = 6;
    localparam int CODE_LO   = 2;
    localparam int CODE_W    = 4;
    localparam int BR_LO     = 2;   // branch conditions 3:2
    localparam int BR_W      = 2;
    localparam int EVT_W     = 3;
    localparam int EVT_EXC   = 0;
    localparam int EVT_INT   = 1;
    localparam int EVT_RFE   = 2;

    // ==========================================================
    // Reset values and constants
    localparam logic [STACK_W-1:0] STACK_RST = 6'h00;
    localparam logic [NUM_INT-1:0] MASK_RST  = 8'h00;
    localparam logic [31:0]        GEN_VECTOR = 32'h8000_0080;

    typedef enum logic [3:0] {
        EXC_INT     = 4'b0000,
        EXC_TLB_MOD = 4'b0001,
        EXC_TLB_LD  = 4'b0010,
        EXC_TLB_ST  = 4'b0011,
        EXC_ADR_LD  = 4'b0100,
        EXC_ADR_ST  = 4'b0101,
        EXC_IBUS    = 4'b0110,
        EXC_DBUS    = 4'b0111,
        EXC_SYSCALL = 4'b1000,
        EXC_BREAK   = 4'b1001,
        EXC_RESINST = 4'b1010,
        EXC_COPUNU  = 4'b1011,
        EXC_OVF     = 4'b1100,
        EXC_RSV13   = 4'b1101,
        EXC_RSV14   = 4'b1110,
        EXC_RSV15   = 4'b1111
    } exc_code_t;

endpackage

// file: src/exc_mode_ctrl.sv
/*
 * Exception and interrupt control: mode stack, interrupt gating, cause
 * code, branch condition sampling and an APB register slave.
 * Assumes the core pulses exc_take for one cycle when it takes an
 * exception and rfe_exec when it retires a restore instruction.
 */
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
module exc_mode_ctrl
    import exc_ctrl_pkg::*;
(
    input  wire logic                           clk,          // 50 MHz clock.
    input  wire logic                           rst,          // Async reset, high.
    input  wire logic                           ce,           // Clock enable.
    input  wire logic                           psel,         // APB select.
    input  wire logic                           penable,      // APB enable.
    input  wire logic                           pwrite,       // APB direction.
    input  wire logic [7:0]                     paddr,        // APB byte address.
    input  wire logic [31:0]                    pwdata,       // APB write data.
    output logic      [31:0]                    prdata,       // APB read data.
    output logic                                pready,       // APB ready.
    output logic                                pslverr,      // APB error.
    input  wire logic [exc_ctrl_pkg::NUM_HW-1:0] hw_int,      // External lines.
    input  wire logic [exc_ctrl_pkg::BR_W-1:0]  branch_condition_input, // 3:2.
    input  wire logic                           exc_take,     // Exception taken.
    input  wire exc_ctrl_pkg::exc_code_t        exc_code_in,  // Its cause.
    input  wire logic                           rfe_exec,     // Restore pulse.
    input  wire logic                           br_eval,      // Branch test.
    input  wire logic                           br_sel,       // 0: cond 2, 1: 3.
    input  wire logic                           br_on_true,   // Branch if set.
    output logic                                br_taken,     // Branch result.
    output logic                                int_req,      // Interrupt to core.
    output logic      [31:0]                    exc_vector,   // Target address.
    output logic                                user_mode,    // 1 = user.
    output logic                                irq           // Event interrupt.
);
    import exc_ctrl_pkg::*;

    // ==========================================================
    // Declarations
    logic [STACK_W-1:0] stack;
    logic [NUM_HW-1:0]  hw_sync;
    logic [BR_W-1:0]    br_sync;
    logic [NUM_INT-1:0] int_mask;
    logic [NUM_SW-1:0]  sw_pend;
    logic [NUM_INT-1:0] pending;
    exc_code_t          cause_code;
    logic [EVT_W-1:0]   evt_stat;
    logic [EVT_W-1:0]   evt_mask;
    logic [NUM_INT-1:0] next_int_mask;
    logic [NUM_SW-1:0]  next_sw_pend;
    exc_code_t          next_cause_code;
    logic [EVT_W-1:0]   next_evt_stat;
    logic [EVT_W-1:0]   next_evt_mask;
    logic [31:0]        next_exc_vector;
    logic               next_br_taken;
    logic [31:0]        next_prdata;
    logic               next_pslverr;
    logic               wr_acc;
    logic               rd_setup;
    logic               st_wr;
    logic [EVT_W-1:0]   evt_now;

    function automatic logic addr_known(input logic [7:0] a);
        return a == STATUS_OFS || a == CAUSE_OFS || a == BRANCH_CONDITION_INPUT_OFS ||
               a == EVT_STAT_OFS || a == EVT_MASK_OFS;
    endfunction

    // ==========================================================
    // Input sampling
    // Two stages on every pin input, so the core sees a change two clocks late.
    // lines sampled
    level_sync #(.W(NUM_HW)) u_hw_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (hw_int),
        .dout (hw_sync)
    );

    level_sync #(.W(BR_W)) u_br_sync (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (branch_condition_input),
        .dout (br_sync)
    );

    // ==========================================================
    // Mode stack
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign st_wr    = wr_acc && paddr == STATUS_OFS;

    // An exception and a status write in one cycle: the push wins and the
    // stack half of the write is lost, while the mask half still lands.
    // entry pushes pairs
    mode_stack u_stack (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .push     (exc_take),
        .pop      (rfe_exec),
        .load     (st_wr),
        .load_val (pwdata[STACK_W-1:0]),
        .stack    (stack)
    );

    assign user_mode = stack[CUR_UM];

    // ==========================================================
    // Interrupt gating
    // The lines sit above the software bits, in the same order as the mask.
    // all pending shown
    assign pending = {hw_sync, sw_pend};
    assign int_req = stack[CUR_IE] && |(pending & int_mask);
    // Read data is captured in the setup cycle, so no access needs a wait state.
    assign pready  = 1'b1;

    // The event line is a plain level of the sticky bits, so software must
    // clear a status bit or its mask bit before the line drops.
    assign irq     = |(evt_stat & evt_mask);

    // ==========================================================
    // Next values for controller registers
    always_comb begin
        evt_now = '0;
        evt_now[EVT_EXC] = exc_take;
        evt_now[EVT_INT] = exc_take && exc_code_in == EXC_INT;
        evt_now[EVT_RFE] = rfe_exec;

        next_int_mask   = int_mask;
        next_sw_pend    = sw_pend;
        next_cause_code = cause_code;
        next_evt_mask   = evt_mask;
        next_exc_vector = exc_vector;
        next_br_taken   = br_taken;
        next_evt_stat   = evt_stat;
        next_prdata     = prdata;
        next_pslverr    = pslverr;

        if (st_wr) begin
            next_int_mask = pwdata[MASK_LO +: NUM_INT];
        end
        // Only the two software bits of the pending field can be written.
        if (wr_acc && paddr == CAUSE_OFS) begin
            next_sw_pend = pwdata[MASK_LO +: NUM_SW];
        end
        if (wr_acc && paddr == EVT_MASK_OFS) begin
            next_evt_mask = pwdata[EVT_W-1:0];
        end
        // Write-one-to-clear; a same-cycle event still sets.
        if (wr_acc && paddr == EVT_STAT_OFS) begin
            next_evt_stat = evt_stat & ~pwdata[EVT_W-1:0];
        end
        next_evt_stat = next_evt_stat | evt_now;

        if (exc_take) begin
            next_cause_code = exc_code_in;
            next_exc_vector = GEN_VECTOR;
        end

        if (br_eval) begin
            next_br_taken = (br_sel ? br_sync[1] : br_sync[0]) == br_on_true;
        end

        // Read data is latched in the setup phase so it can come from a flop.
        if (rd_setup) begin
            next_pslverr = !addr_known(paddr);
            next_prdata  = '0;
            unique case (paddr)
                STATUS_OFS: begin
                    next_prdata[STACK_W-1:0]        = stack;
                    next_prdata[MASK_LO +: NUM_INT] = int_mask;
                end
                CAUSE_OFS: begin
                    next_prdata[CODE_LO +: CODE_W]  = cause_code;
                    next_prdata[MASK_LO +: NUM_INT] = pending;
                end
                BRANCH_CONDITION_INPUT_OFS: begin
                    next_prdata[BR_LO +: BR_W] = br_sync;
                end
                EVT_STAT_OFS: begin
                    next_prdata[EVT_W-1:0] = evt_stat;
                end
                EVT_MASK_OFS: begin
                    next_prdata[EVT_W-1:0] = evt_mask;
                end
                default: begin
                    next_prdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_mask   <= MASK_RST;
            sw_pend    <= '0;
            cause_code <= EXC_INT;
            evt_stat   <= '0;
            evt_mask   <= '0;
            exc_vector <= '0;
            br_taken   <= 1'b0;
            prdata     <= '0;
            pslverr    <= 1'b0;
        end else if (ce) begin
            int_mask   <= next_int_mask;
            sw_pend    <= next_sw_pend;
            cause_code <= next_cause_code;
            evt_stat   <= next_evt_stat;
            evt_mask   <= next_evt_mask;
            exc_vector <= next_exc_vector;
            br_taken   <= next_br_taken;
            prdata     <= next_prdata;
            pslverr    <= next_pslverr;
        end
    end

    // ==========================================================
    // Checks
    // Every check runs on the processor clock and is dropped during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // The mode stack moves as a unit on entry and on restore.
    entry_clears_cur_a: assert property (ce && exc_take |=> stack[1:0] == '0)
        else $error("current pair not cleared on entry");

    entry_saves_pair_a: assert property (
        ce && exc_take |=> stack[3:2] == $past(stack[1:0]) && stack[5:4] == $past(stack[3:2]))
        else $error("pairs not shifted on entry");

    rfe_pops_a: assert property (
        ce && rfe_exec && !exc_take && !st_wr |=> stack[3:0] == $past(stack[5:2]))
        else $error("restore did not pop the stack");

    // The old pair stays put, so a second restore repeats it.
    rfe_keeps_old_a: assert property (
        ce && rfe_exec && !exc_take && !st_wr |=> stack[5:4] == $past(stack[5:4]))
        else $error("restore disturbed the old pair");

    // Entry must shut the interrupt gate and fall back to kernel mode.
    entry_masks_int_a: assert property (ce && exc_take |=> !int_req)
        else $error("interrupt requested right after entry");

    entry_kernel_a: assert property (ce && exc_take |=> !user_mode)
        else $error("user mode left on after entry");

    mask_gates_int_a: assert property (
        ce && st_wr && pwdata[MASK_LO +: NUM_INT] == '0 |=> !int_req)
        else $error("interrupt requested with every source masked");

    mask_write_a: assert property (
        ce && st_wr |=> int_mask == $past(pwdata[MASK_LO +: NUM_INT]))
        else $error("mask write lost");

    soft_pend_a: assert property (
        ce && wr_acc && paddr == CAUSE_OFS
            |=> pending[NUM_SW-1:0] == $past(pwdata[MASK_LO +: NUM_SW]))
        else $error("software pending write lost");

    hw_level_a: assert property (
        ce ##1 ce |=> pending[NUM_INT-1:NUM_SW] == $past(hw_int, 2))
        else $error("hardware pending not two-stage sample");

    // A branch decision only moves when the core asks for one.
    br_result_a: assert property (
        ce && br_eval |=> br_taken == (($past(br_sel) ? $past(br_sync[1]) : $past(br_sync[0]))
                                       == $past(br_on_true)))
        else $error("branch result mismatch");

    br_hold_a: assert property (!ce || !br_eval |=> $stable(br_taken))
        else $error("branch result moved without a test");

    // Cause and vector change only on an exception.
    cause_vector_a: assert property (
        ce && exc_take |=> cause_code == $past(exc_code_in) && exc_vector == GEN_VECTOR)
        else $error("cause or vector not written");

    cause_hold_a: assert property (
        !ce || !exc_take |=> $stable(cause_code) && $stable(exc_vector))
        else $error("cause or vector moved without an exception");

    // Unmapped addresses answer with an error and read as zero.
    unmapped_err_a: assert property (
        ce && rd_setup && !addr_known(paddr) |=> pslverr && prdata == '0)
        else $error("unmapped address did not answer with an error");

    evt_set_wins_a: assert property (ce && exc_take |=> evt_stat[EVT_EXC])
        else $error("event lost against clear");

    // The main scenarios that the bench is expected to reach.
    int_taken_c: cover property (int_req ##[1:4] exc_take && exc_code_in == EXC_INT);
    nest_rfe_c: cover property (exc_take ##[1:8] exc_take ##[1:8] rfe_exec);
    br_taken_c: cover property (br_eval ##1 br_taken);
    irq_out_c: cover property (irq);
    set_wins_c: cover property (ce && exc_take && wr_acc && paddr == EVT_STAT_OFS);
endmodule

// file: src/level_sync.sv
/*
 * Two flip-flop synchroniser for a group of level inputs.
 * Assumes the inputs are quasi-static levels; pulses shorter than one
 * clock may be missed.
 */
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,     // Processor clock.
    input  wire logic         rst,     // Asynchronous reset, active high.
    input  wire logic         ce,      // Clock enable.
    input  wire logic [W-1:0] din,     // Asynchronous levels.
    output logic      [W-1:0] dout     // Synchronised levels.
);
    logic [W-1:0] meta;

    // ==========================================================
    // Synchroniser stages
    // register before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// file: src/mode_stack.sv
/*
 * Three-level kernel/user and interrupt-enable stack.
 * Assumes push, pop and load are single-cycle strobes from the controller;
 * push outranks load, and load outranks pop.
 */
`timescale 1ns/10ps
module mode_stack
    import exc_ctrl_pkg::*;
(
    input  wire logic                             clk,      // Processor clock.
    input  wire logic                             rst,      // Asynchronous reset.
    input  wire logic                             ce,       // Clock enable.
    input  wire logic                             push,     // Exception entry.
    input  wire logic                             pop,      // Restore instruction.
    input  wire logic                             load,     // Software write.
    input  wire logic [exc_ctrl_pkg::STACK_W-1:0] load_val, // Written value.
    output logic      [exc_ctrl_pkg::STACK_W-1:0] stack     // {old, prev, cur}.
);
    import exc_ctrl_pkg::*;

    logic [STACK_W-1:0] next_stack;

    // ==========================================================
    // Next state
    always_comb begin
        next_stack = stack;
        if (push) begin
            next_stack = {stack[STACK_W-3:0], 2'b00};
        end else if (load) begin
            next_stack = load_val;
        end else if (pop) begin
            next_stack = {stack[STACK_W-1:STACK_W-2], stack[STACK_W-1:2]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stack <= STACK_RST;
        end else if (ce) begin
            stack <= next_stack;
        end
    end
endmodule

// file: testbench/ext_agent.sv
/*
 * Model of the external agents that drive the interrupt lines and the
 * branch conditions of the exception controller.
 * Assumes the bench asks for levels on line_req and cond_req; slow adds
 * one clock of lag so that late agents are exercised too.
 */
`timescale 1ns/10ps
module ext_agent
    import exc_ctrl_pkg::*;
(
    input  wire logic                            clk,      // Processor clock.
    input  wire logic                            rst,      // Async reset, high.
    input  wire logic                            slow,     // One extra clock of lag.
    input  wire logic [exc_ctrl_pkg::NUM_HW-1:0] line_req, // Wanted line levels.
    input  wire logic [exc_ctrl_pkg::BR_W-1:0]   cond_req, // Wanted conditions.
    output logic      [exc_ctrl_pkg::NUM_HW-1:0] hw_int,   // Interrupt lines.
    output logic      [exc_ctrl_pkg::BR_W-1:0]   branch_condition_input // Conditions.
);
    import exc_ctrl_pkg::*;

    logic [NUM_HW-1:0] stage_line;
    logic [BR_W-1:0]   stage_cond;

    // ==========================================================
    // Line drivers
    // condition moves with line
    // Both are registered on the same edge with the same lag so that a handler
    // never sees the line without its matching condition.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_line             <= '0;
            stage_cond             <= '0;
            hw_int                 <= '0;
            branch_condition_input <= '0;
        end else begin
            stage_line             <= line_req;
            stage_cond             <= cond_req;
            hw_int                 <= slow ? stage_line : line_req;
            branch_condition_input <= slow ? stage_cond : cond_req;
        end
    end
endmodule

// file: testbench/tb_exc_mode_ctrl.sv
/*
 * Self-checking bench for the exception mode stack controller.
 * Assumes the APB slave answers with pready and the core strobes are
 * single-cycle pulses; ext_agent drives the interrupt and condition pins.
 */
`timescale 1ns/10ps
module tb_exc_mode_ctrl;
    import exc_ctrl_pkg::*;

    logic              clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, exc_vector, rdat;
    logic [NUM_HW-1:0] hw_int, line_req;
    logic [BR_W-1:0]   branch_condition_input, cond_req;
    logic              exc_take, rfe_exec, br_eval, br_sel, br_on_true, slow;
    logic              br_taken, int_req, user_mode, irq, rerr;
    exc_code_t         exc_code_in;
    int                err_count, num_checks;

    exc_mode_ctrl dut(.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hw_int, .branch_condition_input, .exc_take,
        .exc_code_in, .rfe_exec, .br_eval, .br_sel, .br_on_true, .br_taken,
        .int_req, .exc_vector, .user_mode, .irq);
    ext_agent agent(.clk, .rst, .slow, .line_req, .cond_req, .hw_int,
        .branch_condition_input);

    always #10 clk = ~clk;

    // ==========================================================
    // Shared tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    // The bus waits for pready under a bound; no wait state count is assumed.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            print_verdict();
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Kind 0 takes an exception, 1 retires a restore, 2 evaluates a branch.
    task automatic strobe(input int kind, input logic [3:0] c);
        @(posedge clk);
        exc_take    <= (kind == 0);
        rfe_exec    <= (kind == 1);
        br_eval     <= (kind == 2);
        exc_code_in <= exc_code_t'(c);
        @(posedge clk);
        exc_take <= 1'b0;
        rfe_exec <= 1'b0;
        br_eval  <= 1'b0;
        @(negedge clk);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset();
        chk("vector", exc_vector, 32'h0000_0000);
        chk("user", {31'd0, user_mode}, 32'h0000_0000);
        apb(1'b0, STATUS_OFS, '0);
        chk("status", rdat, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("wr err", {31'd0, rerr}, 32'h0000_0001);
        apb(1'b0, 8'h40, '0);
        chk("rd err", {31'd0, rerr}, 32'h0000_0001);
        chk("rd bad", rdat, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic test_stack();
        apb(1'b1, STATUS_OFS, 32'h0000_0003);
        @(negedge clk);
        chk("user", {31'd0, user_mode}, 32'h0000_0001);
        strobe(0, 4'h8);
        chk("user", {31'd0, user_mode}, 32'h0000_0000);
        chk("vector", exc_vector, GEN_VECTOR);
        apb(1'b0, STATUS_OFS, '0);
        chk("push1", rdat, 32'h0000_000C);
        strobe(0, 4'h9);
        apb(1'b0, STATUS_OFS, '0);
        chk("push2", rdat, 32'h0000_0030);
        strobe(1, 4'h0);
        apb(1'b0, STATUS_OFS, '0);
        chk("pop1", rdat, 32'h0000_003C);
        strobe(1, 4'h0);
        chk("user", {31'd0, user_mode}, 32'h0000_0001);
        // With the clock enable low an exception strobe must leave the mode alone.
        @(posedge clk);
        ce <= 1'b0;
        strobe(0, 4'h8);
        chk("frozen", {31'd0, user_mode}, 32'h0000_0001);
        @(posedge clk);
        ce <= 1'b1;
        $display("test stack done");
    endtask

    task automatic test_codes();
        for (int c = 0; c < 16; c++) begin
            strobe(0, 4'(c));
            apb(1'b0, CAUSE_OFS, '0);
            chk("code", rdat & 32'h0000_003C, 32'(c) << CODE_LO);
        end
        $display("test codes done");
    endtask

    task automatic test_gate();
        logic [31:0] m;
        m = 32'h1 << (MASK_LO + NUM_SW + 3);
        apb(1'b1, STATUS_OFS, m);
        line_req <= 6'h08;
        cond_req <= 2'b01;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("gate off", {31'd0, int_req}, 32'h0000_0000);
        apb(1'b0, CAUSE_OFS, '0);
        chk("pending", rdat & 32'h0000_FF00, m);
        apb(1'b1, STATUS_OFS, m | 32'h1);
        @(negedge clk);
        chk("gate on", {31'd0, int_req}, 32'h0000_0001);
        apb(1'b1, STATUS_OFS, 32'h0000_0001);
        @(negedge clk);
        chk("masked", {31'd0, int_req}, 32'h0000_0000);
        apb(1'b1, CAUSE_OFS, 32'h0000_0100);
        apb(1'b1, STATUS_OFS, 32'h0000_0101);
        @(negedge clk);
        chk("soft", {31'd0, int_req}, 32'h0000_0001);
        apb(1'b0, CAUSE_OFS, '0);
        chk("both", rdat & 32'h0000_FF00, m | 32'h100);
        apb(1'b1, CAUSE_OFS, '0);
        apb(1'b1, STATUS_OFS, '0);
        line_req <= '0;
        cond_req <= '0;
        $display("test gate done");
    endtask

    task automatic test_branch();
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            cond_req   <= 2'(k);
            slow       <= k[3];
            br_sel     <= k[2];
            br_on_true <= k[3] ^ k[0];
            repeat (5) @(posedge clk);
            apb(1'b0, BRANCH_CONDITION_INPUT_OFS, '0);
            chk("branch_condition_input", rdat, 32'(k[1:0]) << BR_LO);
            strobe(2, 4'h0);
            chk("br", {31'd0, br_taken}, {31'd0, k[k[2]] == (k[3] ^ k[0])});
        end
        $display("test branch done");
    endtask

    task automatic test_events();
        apb(1'b1, EVT_STAT_OFS, 32'h0000_0007);
        apb(1'b1, EVT_MASK_OFS, 32'h0000_0007);
        @(negedge clk);
        chk("irq idle", {31'd0, irq}, 32'h0000_0000);
        strobe(0, 4'h0);
        chk("irq", {31'd0, irq}, 32'h0000_0001);
        apb(1'b0, EVT_STAT_OFS, '0);
        chk("int event", rdat, 32'h0000_0003);
        strobe(1, 4'h0);
        apb(1'b0, EVT_STAT_OFS, '0);
        chk("events", rdat, 32'h0000_0007);
        apb(1'b1, EVT_MASK_OFS, 32'h0000_0000);
        @(negedge clk);
        chk("irq off", {31'd0, irq}, 32'h0000_0000);
        apb(1'b1, EVT_STAT_OFS, 32'h0000_0007);
        apb(1'b0, EVT_STAT_OFS, '0);
        chk("cleared", rdat, 32'h0000_0000);
        // The clear's access edge meets a new exception: the event must survive.
        fork
            apb(1'b1, EVT_STAT_OFS, 32'h0000_0007);
            begin
                @(posedge clk);
                strobe(0, 4'h8);
            end
        join
        apb(1'b0, EVT_STAT_OFS, '0);
        chk("set wins", rdat, 32'h0000_0001);
        $display("test events done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        clk = 0; rst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = '0; pwdata = '0; exc_take = 0; rfe_exec = 0; br_eval = 0;
        br_sel = 0; br_on_true = 0; slow = 0; line_req = '0; cond_req = '0;
        exc_code_in = EXC_INT;
        err_count = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_stack();
        test_codes();
        test_gate();
        test_branch();
        test_events();
        print_verdict();
    end
endmodule
